/* dccs_regs.svh */
`ifndef DCCS_REGS_SVH
`define DCCS_REGS_SVH

// Register byte offsets
`define DCCS_OFS_CTRL        8'h00
`define DCCS_OFS_KNEE_LOW    8'h04
`define DCCS_OFS_MID_HIGH    8'h08
`define DCCS_OFS_STATUS      8'h0c

// Reset values: analog command, hold below knee, settings at ground
`define DCCS_CTRL_RESET      32'h0000_0005
`define DCCS_SET_RESET       32'h0000_0000

// Control field positions
`define DCCS_CTRL_CMDTYPE    0
`define DCCS_CTRL_KNEESEL    1
`define DCCS_CTRL_WIDTHSEL   3
`define DCCS_CTRL_SOFTOFF    5
`define DCCS_CTRL_LEAD       6

// Setting registers: two 12-bit millivolt levels per word
`define DCCS_SET_LO          0
`define DCCS_SET_HI          16

// AXI responses
`define DCCS_RESP_OKAY       2'h0
`define DCCS_RESP_SLVERR     2'h2

// Quantiser thresholds in millivolts and span between them
`define DCCS_VLOW_MV         12'h271
`define DCCS_VHIGH_MV        12'hc35
`define DCCS_VSPAN_MV        12'h9c4

// Duty codes in 1/128, command codes in 1/1280 of full scale
`define DCCS_DUTY_FULL       11'h080
`define DCCS_CMD_FULL        11'h500
`define DCCS_CMD_MID         11'h280
`define DCCS_CMD_HIGH        11'h480
`define DCCS_HIGH_SPAN       11'h200
`define DCCS_KNEE_SCALE      11'h005

// Lead angle step limits per commutation width
`define DCCS_LEAD_MAX        4'h8
`define DCCS_LEAD_MAX135     4'h6
`define DCCS_LEAD_MAX150     4'h4

// Command absence time (2000 us = 2.0 ms) and clock rate in MHz
`define DCCS_ABSENT_TIME_US  32'h0000_07d0
`define DCCS_CLK_MHZ         32'h0000_0032

`endif

/* dccs_pkg.sv */
`include "dccs_regs.svh"

package dccs_pkg;

  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} dccs_level_t;
  typedef enum logic [1:0] {W_120, W_135, W_150} dccs_width_t;
  typedef enum logic [1:0] {SOFT_NONE, SOFT_135, SOFT_150A, SOFT_150B}
    dccs_soft_t;

  // Millivolt level to a code of 0..full, clamped at both thresholds
  function automatic logic [10:0] dccs_quant(input logic [11:0] mv,
                                            input logic [10:0] full);
    logic [31:0] t;
    t = 32'h0;
    if (mv <= `DCCS_VLOW_MV) return 11'h000;
    if (mv >= `DCCS_VHIGH_MV) return full;
    t = (32'(mv) - 32'(`DCCS_VLOW_MV)) * 32'(full) / 32'(`DCCS_VSPAN_MV);
    return t[10:0];
  endfunction : dccs_quant

endpackage : dccs_pkg

/* dccs_div_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Request and answer of one serial divider
interface dccs_div_if #(parameter int NW = 18, parameter int DW = 11);
  logic          start;
  logic [NW-1:0] num;
  logic [DW-1:0] den;
  logic          done;
  logic [NW-1:0] quo;
  modport master (output start, num, den, input done, quo);
  modport slave  (input start, num, den, output done, quo);
endinterface : dccs_div_if

`default_nettype wire

/* dccs_div.sv */
`timescale 1ns/100ps
`default_nettype none

// Restoring divider, one quotient bit per clock; a start while busy is lost
module dccs_div #(
  parameter int NW = 18,
  parameter int DW = 11
) (
  input  wire logic  clock,
  input  wire logic  rst_n,
  dccs_div_if.slave  div
);
  logic [DW:0]   rem;
  logic [DW-1:0] den;
  logic [7:0]    cnt;
  logic          busy;
  logic [DW:0]   shifted;

  // Trial subtraction of the divisor from the shifted remainder
  assign shifted = {rem[DW-1:0], div.quo[NW-1]};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      div.done <= 1'b0;
      div.quo  <= '0;
      rem      <= '0;
      den      <= '0;
      cnt      <= 8'h00;
    end else begin
      div.done <= 1'b0;
      if (div.start && !busy) begin
        busy    <= 1'b1;
        div.quo <= div.num;
        den     <= div.den;
        rem     <= '0;
        cnt     <= 8'(NW);
      end else if (busy) begin
        if (shifted >= {1'b0, den}) begin
          rem     <= shifted - {1'b0, den};
          div.quo <= {div.quo[NW-2:0], 1'b1};
        end else begin
          rem     <= shifted;
          div.quo <= {div.quo[NW-2:0], 1'b0};
        end
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          busy     <= 1'b0;
          div.done <= 1'b1;
        end
      end
    end
  end
endmodule : dccs_div

`default_nettype wire

/* dccs_pwm_meas.sv */
`timescale 1ns/100ps
`default_nettype none

// Measures the duty of the command PWM as a code of 0..1280
module dccs_pwm_meas #(
  parameter int ABSENT_CYCLES = 100000,
  parameter int CW            = 17
) (
  input  wire logic   clock,
  input  wire logic   rst_n,
  input  wire logic   speedPwm,
  dccs_div_if.master  div,
  output logic        absent,
  output logic [10:0] cmdCode
);
  logic          prevPwm;
  logic [CW-1:0] highCnt;
  logic [CW-1:0] perCnt;
  logic [CW-1:0] offCnt;
  logic          rising;
  logic          stuckHigh;

  assign rising    = speedPwm && !prevPwm;
  assign stuckHigh = speedPwm && (perCnt >= CW'(ABSENT_CYCLES));

  // Each rising edge closes one period; it goes to the divider unless the command was absent
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prevPwm   <= 1'b0;
      highCnt   <= '0;
      perCnt    <= '0;
      offCnt    <= '0;
      absent    <= 1'b1;
      cmdCode   <= 11'h000;
      div.start <= 1'b0;
      div.num   <= '0;
      div.den   <= '0;
    end else begin
      prevPwm   <= speedPwm;
      div.start <= 1'b0;
      if (rising) begin
        div.start <= !absent && (perCnt != '0);
        div.num   <= 28'(highCnt) * 28'(`DCCS_CMD_FULL);
        div.den   <= perCnt;
        highCnt   <= CW'(1);
        perCnt    <= CW'(1);
        absent    <= 1'b0;
      end else begin
        if (!stuckHigh) perCnt <= perCnt + CW'(1);
        if (speedPwm && !stuckHigh) highCnt <= highCnt + CW'(1);
      end
      // Off time of the absence limit means no command at all [R17]
      if (speedPwm) offCnt <= '0;
      else if (offCnt != CW'(ABSENT_CYCLES)) offCnt <= offCnt + CW'(1);
      if (!speedPwm && offCnt == CW'(ABSENT_CYCLES - 1)) absent <= 1'b1;
      if (stuckHigh) cmdCode <= `DCCS_CMD_FULL;
      else if (div.done)
        cmdCode <= (div.quo > 28'(`DCCS_CMD_FULL)) ? `DCCS_CMD_FULL
                                                   : div.quo[10:0];
    end
  end
endmodule : dccs_pwm_meas

`default_nettype wire

/* dccs_top.sv */
// What this block does
// R1 - Three set duties define three curve points
// R2 - Command 50% yields the mid point duty
// R3 - Command 90% yields the high point duty
// R4 - Point duty settings quantise to 1/128 steps
// R5 - Settings should rise low to mid to high
// R6 - Knee command 0..50% from knee setting
// R7 - High select: hold low duty below knee
// R8 - Middle select: ramp knee duty to zero
// R9 - Low select: zero duty below knee
// R10 - Startup forces 120, zero lead, no soft
// R11 - Sensorless drive takes the selected waveform
// R12 - Soft switching steps duty around commutations
// R13 - Soft off: widths 120, 135, 150
// R14 - Soft on: 150 B, 135, 150 A
// R15 - The 150 patterns step duty differently
// R16 - Command is analog level or PWM duty
// R17 - PWM off 2.0 ms means no command
// R18 - Linear between points, last slope clamped above
// R19 - Recompute continually, load at carrier boundary
`timescale 1ns/100ps
`default_nettype none

module dccs_top #(
  parameter int ABSENT_CYCLES = `DCCS_ABSENT_TIME_US * `DCCS_CLK_MHZ,
  parameter int CARRIER_DIV   = 8
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [7:0]         awaddr,
  input  wire logic [2:0]         awprot,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic [2:0]         arprot,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic [11:0]        speedLevelMv,
  input  wire logic               speedPwm,
  input  wire logic               sensorlessMode,
  input  wire logic               commutationEvent,
  output logic                    pwmOut,
  output var dccs_pkg::dccs_width_t commWidth,
  output logic [3:0]              leadAngle,
  output var dccs_pkg::dccs_soft_t  softPattern
);
  import dccs_pkg::*;

  typedef enum logic {CV_LOAD, CV_WAIT} dccs_curve_t;

  // Byte-lane merge for register writes
  function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = data[i*8 +: 8];
    end
    return r;
  endfunction : applyStrb

  // Duty scale in quarters for each soft stage; A steps finer than B
  function automatic logic [2:0] stageFactor(input dccs_soft_t pat,
                                             input logic [1:0] stage);
    logic [2:0] f;
    f = 3'h4;
    unique case (pat)
      SOFT_NONE: f = 3'h4;
      SOFT_135:  f = (stage == 2'h0) ? 3'h2 : (stage == 2'h1) ? 3'h3 : 3'h4;
      SOFT_150A: f = 3'(stage) + 3'h1;
      SOFT_150B: f = (stage == 2'h0) ? 3'h2 : 3'h4;
    endcase
    return f;
  endfunction : stageFactor

  logic [31:0] ctrlReg;
  logic [31:0] kneeLowReg;
  logic [31:0] midHighReg;
  logic        awHeld, wHeld;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        next_awHeld, next_wHeld, next_bvalid, next_rvalid;
  logic        doWrite, wrHit, rdHit;
  logic [31:0] readWord, statusWord;
  logic [7:0]  wrAddr, rdAddr;

  // Write address and data are taken in either order, then answered
  assign doWrite     = awHeld && wHeld && !bvalid;
  assign next_awHeld = doWrite ? 1'b0 : (awHeld || (awvalid && awready));
  assign next_wHeld  = doWrite ? 1'b0 : (wHeld || (wvalid && wready));
  assign next_bvalid = doWrite || (bvalid && !bready);
  assign next_rvalid = (arvalid && arready) || (rvalid && !rready);
  assign wrAddr      = {awAddrQ[7:2], 2'h0};
  assign rdAddr      = {araddr[7:2], 2'h0};
  assign wrHit = (wrAddr == `DCCS_OFS_CTRL) ||
                 (wrAddr == `DCCS_OFS_KNEE_LOW) ||
                 (wrAddr == `DCCS_OFS_MID_HIGH);
  assign rdHit = wrHitRd(rdAddr);

  function automatic logic wrHitRd(input logic [7:0] a);
    return (a == `DCCS_OFS_CTRL) || (a == `DCCS_OFS_KNEE_LOW) ||
           (a == `DCCS_OFS_MID_HIGH) || (a == `DCCS_OFS_STATUS);
  endfunction : wrHitRd

  assign readWord =
    (rdAddr == `DCCS_OFS_CTRL)     ? ctrlReg :
    (rdAddr == `DCCS_OFS_KNEE_LOW) ? kneeLowReg :
    (rdAddr == `DCCS_OFS_MID_HIGH) ? midHighReg :
    (rdAddr == `DCCS_OFS_STATUS)   ? statusWord : 32'h0000_0000;

  // Bus handshake state and write responses
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ  <= 32'h0000_0000;
      wStrbQ  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `DCCS_RESP_OKAY;
    end else begin
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      bvalid  <= next_bvalid;
      awready <= !next_awHeld && !next_bvalid;
      wready  <= !next_wHeld && !next_bvalid;
      if (awvalid && awready) awAddrQ <= awaddr;
      if (wvalid && wready) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) bresp <= wrHit ? `DCCS_RESP_OKAY : `DCCS_RESP_SLVERR;
    end
  end

  // Read channel; one read at a time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `DCCS_RESP_OKAY;
    end else begin
      rvalid  <= next_rvalid;
      arready <= !next_rvalid;
      if (arvalid && arready) begin
        rdata <= readWord;
        rresp <= rdHit ? `DCCS_RESP_OKAY : `DCCS_RESP_SLVERR;
      end
    end
  end

  // Setting registers; the status word is read only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrlReg    <= `DCCS_CTRL_RESET;
      kneeLowReg <= `DCCS_SET_RESET;
      midHighReg <= `DCCS_SET_RESET;
    end else if (doWrite) begin
      if (wrAddr == `DCCS_OFS_CTRL)
        ctrlReg <= applyStrb(ctrlReg, wDataQ, wStrbQ);
      if (wrAddr == `DCCS_OFS_KNEE_LOW)
        kneeLowReg <= applyStrb(kneeLowReg, wDataQ, wStrbQ);
      if (wrAddr == `DCCS_OFS_MID_HIGH)
        midHighReg <= applyStrb(midHighReg, wDataQ, wStrbQ);
    end
  end

  // Decoded settings
  logic        cmdIsAnalog, softOff;
  logic [1:0]  kneeSelRaw, widthSelRaw;
  logic [3:0]  leadSet;
  logic [10:0] kneeCode, lowDuty, midDuty, highDuty, kneeCmd;

  assign cmdIsAnalog = ctrlReg[`DCCS_CTRL_CMDTYPE];
  assign kneeSelRaw  = ctrlReg[`DCCS_CTRL_KNEESEL +: 2];
  assign widthSelRaw = ctrlReg[`DCCS_CTRL_WIDTHSEL +: 2];
  assign softOff     = ctrlReg[`DCCS_CTRL_SOFTOFF];
  assign leadSet     = ctrlReg[`DCCS_CTRL_LEAD +: 4];
  assign kneeCode = dccs_quant(kneeLowReg[`DCCS_SET_LO +: 12],
                               `DCCS_DUTY_FULL);                 // [R6]
  assign lowDuty  = dccs_quant(kneeLowReg[`DCCS_SET_HI +: 12],
                               `DCCS_DUTY_FULL);                 // [R4]
  assign midDuty  = dccs_quant(midHighReg[`DCCS_SET_LO +: 12],
                               `DCCS_DUTY_FULL);                 // [R4]
  assign highDuty = dccs_quant(midHighReg[`DCCS_SET_HI +: 12],
                               `DCCS_DUTY_FULL);                 // [R4]
  // Knee code 0..128 spans 0..640 of the command scale
  assign kneeCmd  = 11'(kneeCode * `DCCS_KNEE_SCALE);           // [R6]

  // Command source selection
  dccs_div_if #(.NW(28), .DW(17)) pwmDiv ();
  dccs_div_if #(.NW(18), .DW(11)) curveDiv ();
  logic        cmdAbsent, pwmAbsent;
  logic [10:0] pwmCmd, cmd;

  dccs_div #(.NW(28), .DW(17)) u_pwm_div (
    .clock (clock),
    .rst_n (rst_n),
    .div   (pwmDiv)
  );
  dccs_div #(.NW(18), .DW(11)) u_curve_div (
    .clock (clock),
    .rst_n (rst_n),
    .div   (curveDiv)
  );
  dccs_pwm_meas #(.ABSENT_CYCLES(ABSENT_CYCLES), .CW(17)) u_meas (
    .clock    (clock),
    .rst_n    (rst_n),
    .speedPwm (speedPwm),
    .div      (pwmDiv),
    .absent   (pwmAbsent),
    .cmdCode  (pwmCmd)
  );

  assign cmdAbsent = !cmdIsAnalog && pwmAbsent;                  // [R17]
  assign cmd = cmdAbsent ? 11'h000 :
               cmdIsAnalog ? dccs_quant(speedLevelMv, `DCCS_CMD_FULL)
                           : pwmCmd;                             // [R16]

  // Curve segment: up to knee, knee to mid, or above mid
  logic        inBelow, inLower, needDiv, yNeg;
  logic [10:0] directY, baseY, dyMag, dx, den;

  assign inBelow = cmd <= kneeCmd;
  assign inLower = cmd <= `DCCS_CMD_MID;
  assign directY =
    (kneeSelRaw == 2'(LVL_LOW)) ? 11'h000 :                      // [R9]
    (kneeSelRaw == 2'(LVL_MID)) ? 11'h000 : lowDuty;             // [R7]
  // A zero knee leaves no ramp to divide over
  assign needDiv = !inBelow || (kneeSelRaw == 2'(LVL_MID) &&
                                kneeCmd != 11'h000);             // [R8]
  assign baseY = inBelow ? 11'h000 : inLower ? lowDuty : midDuty;
  assign yNeg  = !inBelow && (inLower ? (midDuty < lowDuty)
                                      : (highDuty < midDuty));
  assign dyMag = inBelow ? lowDuty :
                 inLower ? ((midDuty < lowDuty) ? lowDuty - midDuty
                                                : midDuty - lowDuty) :
                 ((highDuty < midDuty) ? midDuty - highDuty
                                       : highDuty - midDuty);    // [R1]
  assign dx  = inBelow ? cmd : inLower ? cmd - kneeCmd
                                       : cmd - `DCCS_CMD_MID;
  // Fixed 512 span carries the mid-to-high slope past 90%
  assign den = inBelow ? kneeCmd : inLower ? `DCCS_CMD_MID - kneeCmd
                                           : `DCCS_HIGH_SPAN;    // [R2] [R3]

  // Curve evaluation loops without pause, so any change is picked up
  dccs_curve_t curveState;
  logic [7:0]  mappedDuty;
  logic [11:0] sum;

  assign sum = yNeg ? 12'(baseY) - 12'(curveDiv.quo[10:0])
                    : 12'(baseY) + 12'(curveDiv.quo[10:0]);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      curveState     <= CV_LOAD;
      mappedDuty     <= 8'h00;
      curveDiv.start <= 1'b0;
      curveDiv.num   <= 18'h00000;
      curveDiv.den   <= 11'h000;
    end else begin
      curveDiv.start <= 1'b0;
      unique case (curveState)
        CV_LOAD: begin
          if (needDiv) begin
            curveDiv.start <= 1'b1;
            curveDiv.num   <= 18'(dyMag) * 18'(dx);              // [R18]
            curveDiv.den   <= den;
            curveState     <= CV_WAIT;
          end else begin
            mappedDuty <= directY[7:0];                          // [R7]
          end
        end
        CV_WAIT: begin
          if (curveDiv.done) begin
            curveState <= CV_LOAD;
            // Clamp to 0..128 when the slope runs out of range
            mappedDuty <= sum[11] ? 8'h00 :
                          (sum > 12'(`DCCS_DUTY_FULL)) ? 8'h80
                                                      : sum[7:0]; // [R18]
          end
        end
      endcase
    end
  end

  // Commutation waveform selection
  dccs_width_t next_width;
  dccs_soft_t  next_soft;
  logic [3:0]  next_lead, leadLimit;
  dccs_level_t widthSel;

  assign widthSel = (widthSelRaw == 2'(LVL_LOW)) ? LVL_LOW :
                    (widthSelRaw == 2'(LVL_MID)) ? LVL_MID : LVL_HIGH;
  assign next_width =
    !sensorlessMode ? W_120 :                                    // [R10]
    (widthSel == LVL_MID) ? W_135 :
    (widthSel == LVL_LOW || !softOff) ? W_150 : W_120;           // [R13]
  assign next_soft =
    (!sensorlessMode || softOff) ? SOFT_NONE :                   // [R10]
    (widthSel == LVL_HIGH) ? SOFT_150B :
    (widthSel == LVL_MID) ? SOFT_135 : SOFT_150A;                // [R14]
  // Wider overlap leaves less room for lead
  assign leadLimit = (next_width == W_135) ? `DCCS_LEAD_MAX135 :
                     (next_width == W_150) ? `DCCS_LEAD_MAX150
                                           : `DCCS_LEAD_MAX;
  assign next_lead = !sensorlessMode ? 4'h0 :                    // [R10]
                     (leadSet > leadLimit) ? leadLimit : leadSet; // [R11]

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      commWidth   <= W_120;
      softPattern <= SOFT_NONE;
      leadAngle   <= 4'h0;
    end else begin
      commWidth   <= next_width;                                 // [R11]
      softPattern <= next_soft;
      leadAngle   <= next_lead;
    end
  end

  // Carrier: one enable pulse per CARRIER_DIV clocks, 128 steps a period
  logic [15:0] divCnt;
  logic [6:0]  carrierCnt;
  logic [7:0]  compare;
  logic [1:0]  softStage;
  logic        carrierTick, boundary;
  logic [10:0] scaledDuty;
  logic [7:0]  next_compare;

  assign carrierTick = divCnt == 16'(CARRIER_DIV - 1);
  assign boundary    = carrierTick && carrierCnt == 7'h7f;
  assign scaledDuty  = 11'(mappedDuty) * 11'(stageFactor(softPattern,
                                                         softStage));
  assign next_compare = cmdAbsent ? 8'h00 : scaledDuty[9:2];     // [R15]

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      divCnt     <= 16'h0000;
      carrierCnt <= 7'h00;
      compare    <= 8'h00;
      softStage  <= 2'h3;
      pwmOut     <= 1'b0;
    end else begin
      divCnt <= carrierTick ? 16'h0000 : divCnt + 16'h0001;
      if (carrierTick) carrierCnt <= carrierCnt + 7'h01;
      if (boundary) compare <= next_compare;                     // [R19]
      // A commutation restarts the duty staircase [R12]
      if (commutationEvent && softPattern != SOFT_NONE)
        softStage <= 2'h0;
      else if (boundary && softStage != 2'h3)
        softStage <= softStage + 2'h1;                           // [R12]
      pwmOut <= {1'b0, carrierCnt} < compare;
    end
  end

  assign statusWord = {3'h0, leadAngle, softPattern, commWidth,
                       sensorlessMode, cmdAbsent, cmd, compare};

endmodule : dccs_top

`default_nettype wire

/* dccs_cmd_src.sv */
`timescale 1ns/100ps
`default_nettype none

// Far-side speed command: analog level and a 128-clock command PWM
module dccs_cmd_src (
  input  wire logic        clock,
  input  wire logic        pwmOn,
  input  wire logic [7:0]  highCyc,
  input  wire logic [11:0] levelMv,
  output logic [11:0]      speedLevelMv,
  output logic             speedPwm
);
  logic [6:0] phase = 7'h00;

  // Pin rests low when stopped
  always_ff @(posedge clock) begin
    phase <= phase + 7'h01;
    speedPwm <= pwmOn && ({1'b0, phase} < highCyc);
  end
  assign speedLevelMv = levelMv;
endmodule : dccs_cmd_src

`default_nettype wire

/* dccs_top_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module dccs_top_checker import dccs_pkg::*; (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                arvalid,
  input wire logic                arready,
  input wire logic                rvalid,
  input wire logic                rready,
  input wire logic [31:0]         rdata,
  input wire logic                bvalid,
  input wire logic                bready,
  input wire logic [1:0]          bresp,
  input wire logic                sensorlessMode,
  input wire logic [3:0]          leadAngle,
  input var dccs_pkg::dccs_width_t commWidth,
  input var dccs_pkg::dccs_soft_t  softPattern
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Startup waveform after one register stage
  chk_startup_width: assert property (
    !sensorlessMode [*3] |-> commWidth == W_120) else $error("width");
  chk_startup_lead: assert property (
    !sensorlessMode [*3] |-> leadAngle == 4'h0) else $error("lead");
  chk_startup_soft: assert property (
    !sensorlessMode [*3] |-> softPattern == SOFT_NONE) else $error("soft");
  chk_soft_width: assert property (
    softPattern != SOFT_NONE |-> commWidth ==
      (softPattern == SOFT_135 ? W_135 : W_150)) else $error("pattern");
  chk_lead_clamp: assert property (
    leadAngle <= (commWidth == W_150 ? 4'h4 :
      commWidth == W_135 ? 4'h6 : 4'h8)) else $error("clamp");
  // Bus answers must wait for the master, not vanish
  chk_read_latency: assert property (
    arvalid && arready |=> rvalid) else $error("read late");
  chk_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rhold");
  chk_write_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bhold");

  cover property (softPattern == SOFT_150B);
  cover property (commWidth == W_135);
  cover property (rvalid && rready);
endmodule : dccs_top_checker

bind dccs_top dccs_top_checker dccs_top_checker_inst (.clock, .rst_n,
  .arvalid, .arready, .rvalid, .rready, .rdata, .bvalid, .bready,
  .bresp, .sensorlessMode, .leadAngle, .commWidth, .softPattern);

`default_nettype wire

/* dccs_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module dccs_top_tb;
  import dccs_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, awvalid, wvalid, bready;
  logic        arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic        pwmOut, sensorlessMode, commutationEvent, speedPwm, pwmOn;
  logic [7:0]  awaddr, araddr, highCyc;
  logic [31:0] wdata, rdata, seed = 32'h1;
  logic [1:0]  bresp, rresp;
  logic [11:0] speedLevelMv, levelMv;
  logic [3:0]  leadAngle;
  dccs_width_t commWidth;
  dccs_soft_t  softPattern;
  int n_fail = 0, checks_done = 0, cyc = 0, lo, mi, hi, dlo, dmi, dhi, n;
  int lv[4] = '{0, 1250, 1875, 2875};

  dccs_top #(.ABSENT_CYCLES(200), .CARRIER_DIV(1)) dccs_top_inst (.clock,
    .rst_n, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .speedLevelMv, .speedPwm, .sensorlessMode, .commutationEvent, .pwmOut,
    .commWidth, .leadAngle, .softPattern);
  dccs_cmd_src dccs_cmd_src_inst (.clock, .pwmOn, .highCyc, .levelMv,
    .speedLevelMv, .speedPwm);

  always #10 clock = ~clock;

  // Cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic int q(input int mv, input int full);
    if (mv <= 625) return 0;
    if (mv >= 3125) return full;
    return (mv - 625) * full / 2500;
  endfunction : q

  // Knee sits at command code 320; points at 640 and 1152
  function automatic int expd(input int s, input int mv);
    int c;
    c = q(mv, 1280);
    if (c == 640) return dmi;
    if (c == 1152) return dhi;
    if (s == 0 || (s == 1 && c == 0)) return 0;
    return dlo;
  endfunction : expd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    dccs_width_t ew;
    dccs_soft_t  es;
    {awvalid, wvalid, bready, arvalid, rready, pwmOn} = '0;
    {sensorlessMode, commutationEvent} = '0;
    {awaddr, araddr, wdata, levelMv} = '0;
    highCyc = 8'h40;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    axr(8'h00, d, r);
    chk(d, 32'h5);
    axr(8'h10, d, r);
    chk({d[29:0], r}, 32'h2);
    axw(8'h0c, 32'h0, r);
    chk(32'(r), 32'h2);
    lo = 400 + int'(xs() % 1200);
    mi = lo + int'(xs() % 800);
    hi = mi + int'(xs() % 900);
    dlo = q(lo, 128);
    dmi = q(mi, 128);
    dhi = q(hi, 128);
    axw(8'h04, {4'h0, lo[11:0], 4'h0, 12'h753}, r);
    axw(8'h08, {4'h0, hi[11:0], 4'h0, mi[11:0]}, r);
    sensorlessMode <= 1'b1;
    // Each below-knee select at zero, knee and fixed points
    for (int s = 0; s < 3; s++) begin
      axw(8'h00, 32'h31 | (s << 1), r);
      for (int m = 0; m < 4; m++) begin
        levelMv <= lv[m][11:0];
        repeat (400) @(posedge clock);
        axr(8'h0c, d, r);
        chk(32'(d[7:0]), expd(s, lv[m]));
        chk(32'(d[18:8]), q(lv[m], 1280));
      end
    end
    pwmOn <= 1'b1;
    axw(8'h00, 32'h34, r);
    repeat (1000) @(posedge clock);
    axr(8'h0c, d, r);
    chk(32'(d[19:0]), {12'h0, 1'b0, 11'h280, dmi[7:0]});
    n = 0;
    repeat (128) @(posedge clock) n += pwmOut;
    chk(n, dmi);
    pwmOn <= 1'b0;
    repeat (600) @(posedge clock);
    axr(8'h0c, d, r);
    chk(32'({d[19], d[7:0]}), 32'h100);
    // Width and soft selects, lead asked at its maximum
    for (int f = 0; f < 2; f++) begin
      for (int w = 0; w < 3; w++) begin
        axw(8'h00, 32'h205 | (w << 3) | (f << 5), r);
        @(posedge clock) commutationEvent <= 1'b1;
        @(posedge clock) commutationEvent <= 1'b0;
        repeat (8) @(posedge clock);
        ew = f ? (w == 0 ? W_150 : w == 1 ? W_135 : W_120)
               : (w == 1 ? W_135 : W_150);
        es = f ? SOFT_NONE : (w == 0 ? SOFT_150A :
                              w == 1 ? SOFT_135 : SOFT_150B);
        chk(32'({commWidth, softPattern, leadAngle}), 32'({ew, es,
            (ew == W_150 ? 4'h4 : ew == W_135 ? 4'h6 : 4'h8)}));
      end
    end
    sensorlessMode <= 1'b0;
    repeat (8) @(posedge clock);
    chk(32'({commWidth, softPattern, leadAngle}), 32'h0);
    close_out();
  end
endmodule : dccs_top_tb

`default_nettype wire
